//--- rtl/clk_presc_pkg.sv
package clk_presc_pkg;

    // ******************************************************
    // Register map: word index, byte address is index * 4
    // ******************************************************
    localparam int IDX_WIDTH = 10;
    localparam logic [IDX_WIDTH-1:0] STATUS_IDX = 10'h000;
    localparam logic [IDX_WIDTH-1:0] SPEED_CTRL_IDX = 10'h08f;
    localparam logic [IDX_WIDTH-1:0] RELOAD_IDX = 10'h097;

    // ******************************************************
    // Field positions and reset values
    // ******************************************************
    localparam int RELOAD_WIDTH = 8;
    localparam logic [7:0] RELOAD_RESET = 8'hff;
    localparam logic [7:0] SPEED_CTRL_RESET = 8'h00;
    localparam logic [7:0] SPEED_CTRL_MASK = 8'h7f;
    localparam int X2_BIT = 0;
    localparam int TIMER0_BIT = 1;
    localparam int RSVD_BIT = 7;
    localparam int HCB_X2_BIT = 0;
    localparam int STATUS_RELOAD_LSB = 8;

    // ******************************************************
    // Peripheral tick vector: index i follows speed bit i+1
    // ******************************************************
    localparam int NUM_PERIPH = 6;
    localparam int SERIAL_IDX = 3;
    localparam logic [1:0] SERIAL_MODE_SHIFT = 2'h0;
    localparam logic [1:0] SERIAL_MODE_FIXED = 2'h2;

    // ******************************************************
    // Cycle counts
    // ******************************************************
    localparam logic [2:0] MC_LAST = 3'h5;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // ******************************************************
    // Bus encodings
    // ******************************************************
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN = 2'b10
    } run_state_e;

endpackage

//--- rtl/presc_if.sv
`timescale 1ns/1ps
interface presc_if;
    import clk_presc_pkg::*;
    logic core_tick;
    logic [RELOAD_WIDTH-1:0] reload;
    logic cpu_tick;
    logic [RELOAD_WIDTH-1:0] active_reload;
    modport source (
        output core_tick,
        output reload,
        input cpu_tick,
        input active_reload
    );
    modport divider (
        input core_tick,
        input reload,
        output cpu_tick,
        output active_reload
    );
endinterface

//--- rtl/reload_divider.sv
`timescale 1ns/1ps
module reload_divider #(
    parameter int RELOAD_W = clk_presc_pkg::RELOAD_WIDTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Core tick in, prescaled tick out
    presc_if.divider pif
);
    import clk_presc_pkg::*;

    localparam int CW = RELOAD_W + 1;

    if (RELOAD_W != RELOAD_WIDTH) begin : g_bad_width
        $error("reload_divider width must match the interface");
    end

    logic [RELOAD_W-1:0] act_ff;
    logic [CW-1:0] cnt_ff;
    logic tick_ff;
    logic bypass;
    logic terminal;
    logic [CW-1:0] last_cnt;

    // ******************************************************
    // Period length: 2 * (all ones - reload) core ticks, one core tick at all ones
    // ******************************************************
    assign bypass = (act_ff == {RELOAD_W{1'b1}});
    assign last_cnt = {~act_ff, 1'b0} - CW'(1);
    assign terminal = bypass || (cnt_ff == last_cnt);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
        end else if (pif.core_tick) begin
            if (terminal) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    // New reload only at a boundary, so no period is cut short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff <= RELOAD_W'(RELOAD_RESET);
        end else if (pif.core_tick && terminal) begin
            act_ff <= pif.reload;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= pif.core_tick && terminal;
        end
    end

    assign pif.cpu_tick = tick_ff;
    assign pif.active_reload = act_ff;

    // ******************************************************
    // Checks
    // ******************************************************
    property p_bypass_pass;
        @(posedge hclk) disable iff (!hresetn)
        (pif.core_tick && bypass) |=> tick_ff;
    endproperty
    a_bypass_pass: assert property (p_bypass_pass) else $error("bypass tick lost");

    property p_no_early;
        @(posedge hclk) disable iff (!hresetn)
        (pif.core_tick && !terminal) |=> !tick_ff;
    endproperty
    a_no_early: assert property (p_no_early) else $error("early prescaled tick");

    property p_period_end;
        @(posedge hclk) disable iff (!hresetn)
        (pif.core_tick && (cnt_ff == last_cnt)) |=> (tick_ff && (cnt_ff == '0));
    endproperty
    a_period_end: assert property (p_period_end) else $error("period end missed");

    property p_reload_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(pif.core_tick && terminal) |=> $stable(act_ff);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload changed mid period");

endmodule

//--- rtl/clock_prescaler_speed_select.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Reset loads reload with all ones
// - Any 8-bit reload divides CPU and peripherals
// - Reload zero gives slowest clock
// - Reload all ones gives fastest clock
// - Divide by 2 or 4 times (255-reload), by 1 or 2 at reload 255
// - Clock output runs at oscillator rate
// - Divide-by-two stage, bypassed in double speed
// - Double speed bit applied on half-rate rising
// - Bit 0 selects 12 or 6 periods
// - Reset: double speed from config byte, others clear
// - Peripheral bits ignored outside double speed
// - Peripheral bit clear 6, set 12 periods
// - Serial bit only in modes 0 and 2
module clock_prescaler_speed_select (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Oscillator and configuration
    input wire logic crystal_input,
    input wire logic [7:0] hardware_config_byte,
    // Serial port mode from the serial peripheral
    input wire logic [1:0] serial_port_mode,
    // Clock ticks
    output logic clk_out_tick,
    output logic cpu_clk_tick,
    output logic machine_cycle_tick,
    output logic [clk_presc_pkg::NUM_PERIPH-1:0] periph_clk_tick,
    output logic double_speed_active
);
    import clk_presc_pkg::*;

    // ******************************************************
    // Oscillator input synchroniser
    // ******************************************************
    // Oscillator is sampled by hclk, so it must stay below half of hclk
    logic xtal_meta_ff;
    logic xtal_sync_ff;
    logic xtal_prev_ff;
    logic osc_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_meta_ff <= 1'b0;
            xtal_sync_ff <= 1'b0;
            xtal_prev_ff <= 1'b0;
        end else begin
            xtal_meta_ff <= crystal_input;
            xtal_sync_ff <= xtal_meta_ff;
            xtal_prev_ff <= xtal_sync_ff;
        end
    end

    assign osc_edge = xtal_sync_ff && !xtal_prev_ff;

    // ******************************************************
    // Configuration byte strap
    // ******************************************************
    logic [7:0] hcb_meta_ff;
    logic [7:0] hcb_sync_ff;
    run_state_e state_ff;
    logic [1:0] strap_cnt_ff;
    logic strap_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hcb_meta_ff <= 8'h00;
            hcb_sync_ff <= 8'h00;
        end else begin
            hcb_meta_ff <= hardware_config_byte;
            hcb_sync_ff <= hcb_meta_ff;
        end
    end

    assign strap_done = (strap_cnt_ff == STRAP_WAIT);

    // Strap is taken once the sync chain holds a settled value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_STRAP;
            strap_cnt_ff <= 2'h0;
        end else begin
            case (state_ff)
                ST_STRAP: begin
                    if (strap_done) begin
                        state_ff <= ST_RUN;
                    end else begin
                        strap_cnt_ff <= strap_cnt_ff + 2'h1;
                    end
                end
                ST_RUN: begin
                    state_ff <= ST_RUN;
                end
                default: begin
                    state_ff <= ST_STRAP;
                end
            endcase
        end
    end

    // ******************************************************
    // Bus address phase
    // ******************************************************
    logic addr_valid;
    logic wr_pend_ff;
    logic [IDX_WIDTH-1:0] wr_idx_ff;
    logic [IDX_WIDTH-1:0] addr_idx;

    assign addr_valid = hsel && htrans[1] && hready;
    assign addr_idx = haddr[IDX_WIDTH+1:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= '0;
        end else begin
            // Narrow writes would split a byte register, so they are dropped
            wr_pend_ff <= addr_valid && hwrite && (hsize == HSIZE_WORD);
            wr_idx_ff <= addr_idx;
        end
    end

    // ******************************************************
    // Registers
    // ******************************************************
    logic [7:0] speed_ff;
    logic [7:0] nxt_speed;
    logic [7:0] reload_ff;
    logic [7:0] nxt_reload;
    logic x2_eff_ff;

    always_comb begin
        nxt_speed = speed_ff;
        nxt_reload = reload_ff;
        if (state_ff == ST_STRAP && strap_done) begin
            nxt_speed[X2_BIT] = hcb_sync_ff[HCB_X2_BIT];
        end
        if (wr_pend_ff && state_ff == ST_RUN) begin
            if (wr_idx_ff == SPEED_CTRL_IDX) begin
                // Reserved bit is held at zero whatever is written
                nxt_speed = hwdata[7:0] & SPEED_CTRL_MASK;
            end
            if (wr_idx_ff == RELOAD_IDX) begin
                nxt_reload = hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ff <= SPEED_CTRL_RESET;
        end else begin
            speed_ff <= nxt_speed;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_ff <= RELOAD_RESET;
        end else begin
            reload_ff <= nxt_reload;
        end
    end

    // ******************************************************
    // Bus read data and response
    // ******************************************************
    presc_if pif ();
    logic [31:0] rd_word;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;

    // Next values are read so a read right after a write sees it
    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_idx)
            SPEED_CTRL_IDX: rd_word[7:0] = nxt_speed;
            RELOAD_IDX: rd_word[7:0] = nxt_reload;
            STATUS_IDX: begin
                rd_word[X2_BIT] = x2_eff_ff;
                rd_word[STATUS_RELOAD_LSB +: RELOAD_WIDTH] = pif.active_reload;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata_ff <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;

    // ******************************************************
    // Divide-by-two stage and speed switch
    // ******************************************************
    logic half_ff;
    logic half_rise;
    logic core_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_ff <= 1'b0;
        end else if (osc_edge) begin
            half_ff <= !half_ff;
        end
    end

    assign half_rise = osc_edge && !half_ff;

    // Mode change only on the half-rate rising edge avoids a runt tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x2_eff_ff <= 1'b0;
        end else if (half_rise) begin
            x2_eff_ff <= speed_ff[X2_BIT];
        end
    end

    // Standard speed passes every second edge, double speed every edge
    assign core_tick = osc_edge && (x2_eff_ff || !half_ff);

    // ******************************************************
    // Reload prescaler
    // ******************************************************
    assign pif.core_tick = core_tick;
    assign pif.reload = reload_ff;

    reload_divider #(
        .RELOAD_W(RELOAD_WIDTH)
    ) u_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .pif(pif)
    );

    // ******************************************************
    // Output ticks
    // ******************************************************
    logic clk_out_ff;
    logic cpu_tick_ff;
    logic cpu_phase_ff;
    logic [2:0] mc_cnt_ff;
    logic machine_tick_ff;
    logic [NUM_PERIPH-1:0] periph_next;
    logic [NUM_PERIPH-1:0] periph_tick_ff;
    logic serial_gate;

    assign serial_gate = (serial_port_mode == SERIAL_MODE_SHIFT)
        || (serial_port_mode == SERIAL_MODE_FIXED);

    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
        logic slow;
        // Without double speed every peripheral runs at standard rate
        assign slow = x2_eff_ff && speed_ff[i+1] && ((i != SERIAL_IDX) || serial_gate);
        // Slow peripherals take every second prescaled tick
        assign periph_next[i] = pif.cpu_tick && (!slow || cpu_phase_ff);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_out_ff <= 1'b0;
            cpu_tick_ff <= 1'b0;
            periph_tick_ff <= '0;
        end else begin
            clk_out_ff <= osc_edge;
            cpu_tick_ff <= pif.cpu_tick;
            periph_tick_ff <= periph_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_phase_ff <= 1'b0;
        end else if (pif.cpu_tick) begin
            cpu_phase_ff <= !cpu_phase_ff;
        end
    end

    // Six prescaled CPU ticks make a machine cycle in either mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_cnt_ff <= 3'h0;
            machine_tick_ff <= 1'b0;
        end else begin
            machine_tick_ff <= pif.cpu_tick && (mc_cnt_ff == MC_LAST);
            if (pif.cpu_tick) begin
                mc_cnt_ff <= (mc_cnt_ff == MC_LAST) ? 3'h0 : mc_cnt_ff + 3'h1;
            end
        end
    end

    assign clk_out_tick = clk_out_ff;
    assign cpu_clk_tick = cpu_tick_ff;
    assign machine_cycle_tick = machine_tick_ff;
    assign periph_clk_tick = periph_tick_ff;
    assign double_speed_active = x2_eff_ff;

    // ******************************************************
    // Checks
    // ******************************************************
    sequence s_half_rise;
        half_rise;
    endsequence

    property p_x2_hold;
        @(posedge hclk) disable iff (!hresetn)
        !half_rise |=> $stable(x2_eff_ff);
    endproperty
    a_x2_hold: assert property (p_x2_hold) else $error("speed switched off edge");

    property p_x2_follow;
        @(posedge hclk) disable iff (!hresetn)
        s_half_rise |=> (x2_eff_ff == $past(speed_ff[X2_BIT]));
    endproperty
    a_x2_follow: assert property (p_x2_follow) else $error("speed bit not applied");

    property p_ignore;
        @(posedge hclk) disable iff (!hresetn)
        (cpu_tick_ff && !$past(x2_eff_ff)) |-> (periph_tick_ff == {NUM_PERIPH{1'b1}});
    endproperty
    a_ignore: assert property (p_ignore) else $error("peripheral bit used in std");

    property p_fast_t0;
        @(posedge hclk) disable iff (!hresetn)
        (cpu_tick_ff && $past(x2_eff_ff && !speed_ff[TIMER0_BIT])) |-> periph_tick_ff[0];
    endproperty
    a_fast_t0: assert property (p_fast_t0) else $error("fast timer0 tick lost");

    property p_machine;
        @(posedge hclk) disable iff (!hresetn)
        machine_tick_ff |-> (cpu_tick_ff && !$past(machine_tick_ff));
    endproperty
    a_machine: assert property (p_machine) else $error("machine tick misplaced");

    property p_reload_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (reload_ff == RELOAD_RESET);
    endproperty
    a_reload_reset: assert property (p_reload_reset) else $error("reload reset wrong");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> !speed_ff[RSVD_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_ready;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> (hreadyout_ff && !hresp_ff);
    endproperty
    a_ready: assert property (p_ready) else $error("bus stalled or errored");

endmodule

//--- test/crystal_osc_model.sv
`timescale 1ns/1ps
module crystal_osc_model #(
    parameter int HALF_NS = 160,
    parameter int START_NS = 13
) (
    // Oscillator pin
    output logic crystal_input
);
    // Offset keeps edges away from hclk edges so the synchroniser delay stays fixed
    initial begin
        crystal_input = 1'b0;
        #(START_NS);
        forever begin
            #(HALF_NS) crystal_input = ~crystal_input;
        end
    end
endmodule

//--- test/test_clock_prescaler_speed_select.sv
`timescale 1ns/1ps
module test_clock_prescaler_speed_select;
    import clk_presc_pkg::*;
    localparam logic [31:0] A_STAT = {20'h0, STATUS_IDX, 2'b00};
    localparam logic [31:0] A_SPD = {20'h0, SPEED_CTRL_IDX, 2'b00};
    localparam logic [31:0] A_REL = {20'h0, RELOAD_IDX, 2'b00};
    // Oscillator period is 8 hclk cycles
    localparam int P = 8;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, crystal_input;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, serial_port_mode;
    logic [2:0] hsize;
    logic [7:0] hardware_config_byte;
    logic clk_out_tick, cpu_clk_tick, machine_cycle_tick, double_speed_active;
    logic [NUM_PERIPH-1:0] periph_clk_tick;
    int failures = 0;
    int check_count = 0;
    assign hready = hreadyout;
    clock_prescaler_speed_select clock_prescaler_speed_select_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .crystal_input(crystal_input),
        .hardware_config_byte(hardware_config_byte), .serial_port_mode(serial_port_mode),
        .clk_out_tick(clk_out_tick), .cpu_clk_tick(cpu_clk_tick),
        .machine_cycle_tick(machine_cycle_tick), .periph_clk_tick(periph_clk_tick),
        .double_speed_active(double_speed_active));
    crystal_osc_model crystal_osc_model_i (.crystal_input(crystal_input));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: bus hang", $time);
            finish_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [2:0] sz);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, HSIZE_WORD);
        check(rd, exp);
    endtask
    task automatic next_tick(input bit outclk, output int n);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while ((outclk ? clk_out_tick : cpu_clk_tick) !== 1'b1 && n < 20000);
        if ((outclk ? clk_out_tick : cpu_clk_tick) !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: tick timeout", $time);
            finish_test();
        end
    endtask
    // First two intervals after a change may be partial, so they are skipped
    task automatic period(input bit outclk, input int exp);
        int n;
        next_tick(outclk, n);
        next_tick(outclk, n);
        next_tick(outclk, n);
        check(32'(n), 32'(exp));
    endtask
    task automatic window(input logic [5:0] slow);
        int n, mc;
        int pc[6];
        mc = 0;
        pc = '{default: 0};
        repeat (12) begin
            next_tick(1'b0, n);
            mc += int'(machine_cycle_tick === 1'b1);
            for (int i = 0; i < 6; i++) begin
                pc[i] += int'(periph_clk_tick[i] === 1'b1);
            end
        end
        check(32'(mc), 32'h2);
        for (int i = 0; i < 6; i++) begin
            check(32'(pc[i]), slow[i] ? 32'h6 : 32'hc);
        end
    endtask
    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_check(A_SPD, 32'h0);
        rd_check(A_REL, 32'hff);
        rd_check(A_STAT, 32'h0000ff00);
        rd_check(32'h40, 32'h0);
        period(1'b1, P);
        period(1'b0, 2 * P);
        $display("reset test done");
    endtask
    task automatic t_standard();
        bus(1'b1, A_SPD, 32'h7e, HSIZE_WORD);
        bus(1'b1, A_REL, 32'hfe, HSIZE_WORD);
        rd_check(A_REL, 32'hfe);
        period(1'b0, 4 * P);
        window(6'h00);
        $display("standard test done");
    endtask
    task automatic t_double();
        bus(1'b1, A_SPD, 32'h01, HSIZE_WORD);
        bus(1'b1, A_REL, 32'hff, HSIZE_WORD);
        period(1'b0, P);
        check({31'h0, double_speed_active}, 32'h1);
        rd_check(A_STAT, 32'h0000ff01);
        window(6'h00);
        bus(1'b1, A_REL, 32'hfe, HSIZE_WORD);
        period(1'b0, 2 * P);
        $display("double speed test done");
    endtask
    task automatic t_periph();
        bus(1'b1, A_SPD, 32'h7f, HSIZE_WORD);
        bus(1'b1, A_REL, 32'hff, HSIZE_WORD);
        for (int m = 0; m < 4; m++) begin
            @(posedge hclk);
            serial_port_mode <= 2'(m);
            // Serial bit only counts in modes 0 and 2
            window((m == 0 || m == 2) ? 6'h3f : 6'h37);
        end
        $display("peripheral test done");
    endtask
    task automatic t_slow();
        int n;
        bus(1'b1, A_SPD, 32'h01, HSIZE_WORD);
        bus(1'b1, A_REL, 32'h00, HSIZE_WORD);
        period(1'b0, 510 * P);
        bus(1'b1, A_REL, 32'hff, HSIZE_WORD);
        rd_check(A_STAT, 32'h00000001);
        next_tick(1'b0, n);
        period(1'b0, P);
        bus(1'b1, A_SPD, 32'h00, HSIZE_WORD);
        bus(1'b1, A_REL, 32'h00, HSIZE_WORD);
        period(1'b0, 1020 * P);
        $display("slow clock test done");
    endtask
    task automatic t_narrow_strap();
        bus(1'b1, A_SPD, 32'h7f, 3'h0);
        rd_check(A_SPD, 32'h0);
        hardware_config_byte <= 8'h01;
        do_reset();
        rd_check(A_SPD, 32'h1);
        $display("narrow and strap test done");
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        hardware_config_byte = 8'h00;
        serial_port_mode = 2'h1;
        do_reset();
        t_reset();
        t_standard();
        t_double();
        t_periph();
        t_slow();
        t_narrow_strap();
        finish_test();
    end
endmodule
